/* File: adpp_consts.vh */
`ifndef ADPP_CONSTS_VH
`define ADPP_CONSTS_VH
// register byte offsets
`define ADPP_REG_CTRL      4'h0
`define ADPP_REG_GAIN      4'h4
`define ADPP_REG_TRIM      4'h8
`define ADPP_REG_STATUS    4'hC
// control register fields
`define ADPP_CTRL_DIGEN    0
`define ADPP_CTRL_SLEEP    1
`define ADPP_CTRL_STBY_A   2
`define ADPP_CTRL_STBY_B   3
`define ADPP_CTRL_FMT      4
`define ADPP_CTRL_DDR      5
`define ADPP_CTRL_ILV      6
`define ADPP_CTRL_PINSEL   7
// trim register fields
`define ADPP_TRIM_EN       0
`define ADPP_TRIM_HOLD     1
`define ADPP_TRIM_TC_LSB   4
// reset values
`define ADPP_CTRL_RST      8'h00
`define ADPP_GAIN_RST      4'h0
`define ADPP_TRIM_RST      8'h02
// pipeline depths
`define ADPP_RAW_LAT       16
`define ADPP_DIG_EXTRA     4
`define ADPP_DIG_EXTRA_W   2
// codes
`define ADPP_GAIN_MAX      4'hC
`define ADPP_TC_MAX        4'hB
`define ADPP_OB_POS        14'h3FFF
`define ADPP_OB_NEG        14'h0000
`define ADPP_TC_POS        14'h1FFF
`define ADPP_TC_NEG        14'h2000
// trim limit, about 10 mV of a 2 Vpp span at 14 bits
`define ADPP_TRIM_LIM      14'h0052
// timing in microseconds and nanoseconds
`define ADPP_WAKE_FULL_US  100
`define ADPP_WAKE_STBY_US  50
`define ADPP_CLK_NS        25
`define ADPP_SLOW_NS       1000
`define ADPP_WAKE_FULL_CYC ((`ADPP_WAKE_FULL_US*1000)/`ADPP_CLK_NS)
`define ADPP_WAKE_STBY_CYC ((`ADPP_WAKE_STBY_US*1000)/`ADPP_CLK_NS)
`define ADPP_SLOW_CYC      ((`ADPP_SLOW_NS+`ADPP_CLK_NS-1)/`ADPP_CLK_NS)
`endif

/* File: adpp_top.v */
// Contract
// - reset gives raw samples, sixteen sample delay
// - processing only after digital enable set
// - processing adds pipeline stages to latency
// - gain zero to six dB, half steps
// - gain resets to zero dB
// - trim estimates and subtracts bounded dc offset
// - unheld trim updates every sample
// - four bit averaging time select
// - hold low freezes the estimate
// - trim disabled after reset
// - sleep and standby by bits or pins
// - pins low normal, first pin sleep
// - pins one and three: channel A standby
// - all pins high: interleave on B
// - sleep floats outputs, 100 us wake
// - standby releases after 50 us
// - slow sample clock enters low power
// - twos complement or offset binary coding
// - overdrive saturates to full scale codes
// - 14 bit samples with forwarded clock
// - DDR or CMOS interface select
// - DDR even bits rise, odd fall
// - interleave floats channel A bus
//
// The register offsets and register access over Wishbone are this design's own decisions.
`include "adpp_consts.vh"
module adpp_top #(
    parameter WAKE_FULL_CYC = `ADPP_WAKE_FULL_CYC,
    parameter WAKE_STBY_CYC = `ADPP_WAKE_STBY_CYC
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        samp_clk_i,
    input  wire [13:0] raw_a_i,
    input  wire [13:0] raw_b_i,
    input  wire        ovr_a_i,
    input  wire        ovr_b_i,
    input  wire        power_pin_1_i,
    input  wire        power_pin_2_i,
    input  wire        power_pin_3_i,
    input  wire        format_select_pin_i,
    input  wire        serial_select_pin_i,
    output reg  [13:0] chan_a_bus_o,
    output reg         chan_a_bus_oe_o,
    output reg  [13:0] chan_b_bus_o,
    output reg         chan_b_bus_oe_o,
    output reg         fwd_clock_pos_o,
    output reg         fwd_clock_oe_o,
    output reg         ddr_mode_o,
    output reg         core_sleep_o,
    output reg         core_stby_a_o,
    output reg         core_stby_b_o,
    output reg         low_power_o
);
    // register storage
    reg  [7:0]  ctrl;             // control bits
    reg  [3:0]  gain;             // gain in half dB steps
    reg  [7:0]  trim;             // trim enable, hold, time constant
    // three stage synchronisers for pins and sample clock; raw data takes two stages
    reg  [2:0]  sc_sy;            // sample clock sync
    reg  [2:0]  p1_sy, p2_sy, p3_sy, fp_sy, sp_sy; // pin syncs, three stages
    reg  [13:0] a_s1, a_s2;       // data capture, registered every cycle, used on the sample edge
    reg  [13:0] b_s1, b_s2;
    reg         oa_s1, oa_s2, ob_s1, ob_s2;
    // edges judged on stages two and three
    wire        samp_rise = sc_sy[1] & ~sc_sy[2];
    wire        samp_fall = sc_sy[2] & ~sc_sy[1];
    // pin levels count once second and third stages agree
    reg         pin_1, pin_2, pin_3, pin_fmt, pin_ser;

    // synchronisers; first stage read only by second
    always @(posedge clk_i) begin
        if (rst_i) begin
            sc_sy <= 3'b000;
            p1_sy <= 3'h0;
            p2_sy <= 3'h0;
            p3_sy <= 3'h0;
            fp_sy <= 3'h0;
            sp_sy <= 3'h0;
            pin_1 <= 1'b0;
            pin_2 <= 1'b0;
            pin_3 <= 1'b0;
            pin_fmt <= 1'b0;
            pin_ser <= 1'b0;
        end else begin
            sc_sy <= {sc_sy[1:0], samp_clk_i};
            p1_sy <= {p1_sy[1:0], power_pin_1_i};
            p2_sy <= {p2_sy[1:0], power_pin_2_i};
            p3_sy <= {p3_sy[1:0], power_pin_3_i};
            fp_sy <= {fp_sy[1:0], format_select_pin_i};
            sp_sy <= {sp_sy[1:0], serial_select_pin_i};
            // a level changes only when stages two and three agree
            if (p1_sy[1] == p1_sy[2]) pin_1 <= p1_sy[2];
            if (p2_sy[1] == p2_sy[2]) pin_2 <= p2_sy[2];
            if (p3_sy[1] == p3_sy[2]) pin_3 <= p3_sy[2];
            if (fp_sy[1] == fp_sy[2]) pin_fmt <= fp_sy[2];
            if (sp_sy[1] == sp_sy[2]) pin_ser <= sp_sy[2];
        end
    end

    // data is stable around the sample edge; take it two stages deep
    always @(posedge clk_i) begin
        if (rst_i) begin
            a_s1 <= 14'h0000; a_s2 <= 14'h0000;
            b_s1 <= 14'h0000; b_s2 <= 14'h0000;
            oa_s1 <= 1'b0; oa_s2 <= 1'b0; ob_s1 <= 1'b0; ob_s2 <= 1'b0;
        end else begin
            a_s1 <= raw_a_i; a_s2 <= a_s1;
            b_s1 <= raw_b_i; b_s2 <= b_s1;
            oa_s1 <= ovr_a_i; oa_s2 <= oa_s1;
            ob_s1 <= ovr_b_i; ob_s2 <= ob_s1;
        end
    end

    // control source: pins when pin select is set, else register bits
    wire use_pins = ctrl[`ADPP_CTRL_PINSEL];
    reg  m_sleep, m_stby_a, m_ilv;
    always @* begin
        m_sleep  = 1'b0;
        m_stby_a = 1'b0;
        m_ilv    = 1'b0;
        if (use_pins) begin
            case ({pin_1, pin_2, pin_3})
                3'b000: ; // normal
                3'b100: m_sleep = 1'b1;
                3'b101: m_stby_a = 1'b1;
                3'b111: m_ilv = 1'b1;
                default: ; // unsupported codes stay normal
            endcase
        end else begin
            m_sleep  = ctrl[`ADPP_CTRL_SLEEP];
            m_stby_a = ctrl[`ADPP_CTRL_STBY_A];
            m_ilv    = ctrl[`ADPP_CTRL_ILV];
        end
    end
    // pins offer no standby for channel B
    wire m_stby_b = use_pins ? 1'b0 : ctrl[`ADPP_CTRL_STBY_B];
    wire fmt_tc   = use_pins ? pin_fmt : ctrl[`ADPP_CTRL_FMT];
    wire ddr_sel  = use_pins ? pin_ser : ctrl[`ADPP_CTRL_DDR];

    // wake counters: data held invalid until counts expire
    reg [31:0] wake_full, wake_a, wake_b;
    reg        was_sleep, was_a, was_b;
    // slow clock detector: gap between sample edges in system cycles
    reg [7:0]  gap;
    reg        slow;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_full <= 32'h0000_0000;
            wake_a <= 32'h0000_0000;
            wake_b <= 32'h0000_0000;
            was_sleep <= 1'b0; was_a <= 1'b0; was_b <= 1'b0;
            gap <= 8'h00;
            slow <= 1'b0;
        end else begin
            was_sleep <= m_sleep;
            was_a <= m_stby_a;
            was_b <= m_stby_b;
            if (was_sleep & ~m_sleep) wake_full <= WAKE_FULL_CYC;
            else if (m_sleep) wake_full <= 32'h0000_0000;
            else if (wake_full != 32'h0000_0000) wake_full <= wake_full - 32'h0000_0001;
            if (was_a & ~m_stby_a) wake_a <= WAKE_STBY_CYC;
            else if (wake_a != 32'h0000_0000) wake_a <= wake_a - 32'h0000_0001;
            if (was_b & ~m_stby_b) wake_b <= WAKE_STBY_CYC;
            else if (wake_b != 32'h0000_0000) wake_b <= wake_b - 32'h0000_0001;
            // a long wait between sample edges means under 1 MSPS
            if (samp_rise) begin
                gap <= 8'h00;
                slow <= 1'b0;
            end else if (gap >= `ADPP_SLOW_CYC) begin
                slow <= 1'b1;
            end else begin
                gap <= gap + 8'h01;
            end
        end
    end
    // valid once the full and own-channel wake counts are spent
    wire valid_a = ~m_sleep & ~m_stby_a & (wake_full == 32'h0) & (wake_a == 32'h0);
    wire valid_b = ~m_sleep & ~m_stby_b & (wake_full == 32'h0) & (wake_b == 32'h0);

    // gain in fixed point, 2.7 format, approx 10^(g/40)
    reg [8:0] gmul;
    always @* begin
        case (gain)
            4'd0:  gmul = 9'd128;
            4'd1:  gmul = 9'd136;
            4'd2:  gmul = 9'd144;
            4'd3:  gmul = 9'd152;
            4'd4:  gmul = 9'd161;
            4'd5:  gmul = 9'd171;
            4'd6:  gmul = 9'd181;
            4'd7:  gmul = 9'd192;
            4'd8:  gmul = 9'd203;
            4'd9:  gmul = 9'd215;
            4'd10: gmul = 9'd228;
            4'd11: gmul = 9'd242;
            default: gmul = 9'd256;
        endcase
    end

    // processing of one channel in signed offset-removed form
    wire        digen = ctrl[`ADPP_CTRL_DIGEN];
    wire [3:0]  tc = trim[`ADPP_TRIM_TC_LSB+3:`ADPP_TRIM_TC_LSB];
    wire [4:0]  shf = 5'd20 + {1'b0, (tc > `ADPP_TC_MAX) ? `ADPP_TC_MAX : tc};
    // leaky sum: loses one estimate each sample
    reg  signed [45:0] acc_a, acc_b; // offset estimate, scaled by 2^shf
    wire signed [14:0] sa = {1'b0, a_s2} - 15'sd8192;
    wire signed [14:0] sb = {1'b0, b_s2} - 15'sd8192;
    // scaled back, the estimate fits 15 bits
    wire signed [45:0] sh_a = acc_a >>> shf;
    wire signed [45:0] sh_b = acc_b >>> shf;
    wire signed [14:0] est_a = sh_a[14:0];
    wire signed [14:0] est_b = sh_b[14:0];
    // hold high runs the loop, low freezes it
    wire trim_on = digen & trim[`ADPP_TRIM_EN];
    wire trim_run = trim_on & trim[`ADPP_TRIM_HOLD]; // hold at 0 freezes
    // saturation wins over coding
    function [13:0] proc;
        input signed [14:0] s;
        input signed [14:0] e;
        input        [8:0]  g;
        input               ov;
        input               tcf;
        reg signed [15:0] lim;
        reg signed [25:0] p;
        reg signed [15:0] r;
        begin
            lim = (e > 15'sd82) ? 16'sd82 : ((e < -15'sd82) ? -16'sd82 : e);
            p = (s - lim) * $signed({1'b0, g});
            r = p[22:7];
            if (ov | r > 16'sd8191) proc = tcf ? `ADPP_TC_POS : `ADPP_OB_POS;
            else if (r < -16'sd8192) proc = tcf ? `ADPP_TC_NEG : `ADPP_OB_NEG;
            else proc = tcf ? r[13:0] : {~r[13], r[12:0]};
        end
    endfunction

    // raw pipeline plus extra processing stages
    localparam DEPTH = `ADPP_RAW_LAT + `ADPP_DIG_EXTRA;
    reg [13:0] pa [0:DEPTH-1];
    reg [13:0] pb [0:DEPTH-1];
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_a <= 46'sd0;
            acc_b <= 46'sd0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                pa[i] <= 14'h0000;
                pb[i] <= 14'h0000;
            end
        end else if (samp_rise) begin
            if (trim_run) begin
                acc_a <= acc_a + sa - est_a;
                acc_b <= acc_b + sb - est_b;
            end else if (~trim_on) begin
                acc_a <= 46'sd0;
                acc_b <= 46'sd0;
            end
            if (digen) begin
                pa[0] <= proc(sa, trim_on ? est_a : 15'sd0, gmul, oa_s2, fmt_tc);
                pb[0] <= proc(sb, trim_on ? est_b : 15'sd0, gmul, ob_s2, fmt_tc);
            end else begin
                pa[0] <= oa_s2 ? {~fmt_tc, 13'h1FFF} :
                         fmt_tc ? {~a_s2[13], a_s2[12:0]} : a_s2; // raw
                pb[0] <= ob_s2 ? {~fmt_tc, 13'h1FFF} :
                         fmt_tc ? {~b_s2[13], b_s2[12:0]} : b_s2;
            end
            for (i = 1; i < DEPTH; i = i + 1) begin
                pa[i] <= pa[i-1];
                pb[i] <= pb[i-1];
            end
        end
    end
    // bypass taps at sixteen, processing taps four later
    wire [13:0] out_a = digen ? pa[DEPTH-1] : pa[`ADPP_RAW_LAT-1];
    wire [13:0] out_b = digen ? pb[DEPTH-1] : pb[`ADPP_RAW_LAT-1];
    // no extra stage: a word leaves on its tap rise
    wire [13:0] word_a = valid_a ? out_a : 14'h0000;
    wire [13:0] word_b = valid_b ? out_b : 14'h0000;

    // output stage: DDR even bits on rise, odd bits on fall
    reg [13:0] hold_a, hold_b;
    reg        ilv_ph;
    always @(posedge clk_i) begin
        if (rst_i) begin
            chan_a_bus_o <= 14'h0000; chan_b_bus_o <= 14'h0000;
            chan_a_bus_oe_o <= 1'b0; chan_b_bus_oe_o <= 1'b0;
            fwd_clock_pos_o <= 1'b0; fwd_clock_oe_o <= 1'b0;
            ddr_mode_o <= 1'b0; core_sleep_o <= 1'b0;
            core_stby_a_o <= 1'b0; core_stby_b_o <= 1'b0; low_power_o <= 1'b0;
            hold_a <= 14'h0000; hold_b <= 14'h0000; ilv_ph <= 1'b0;
        end else begin
            ddr_mode_o <= ddr_sel;
            core_sleep_o <= m_sleep;
            core_stby_a_o <= m_stby_a;
            core_stby_b_o <= m_stby_b;
            low_power_o <= slow | m_sleep;
            chan_a_bus_oe_o <= ~m_sleep & ~m_ilv;
            chan_b_bus_oe_o <= ~m_sleep;
            fwd_clock_oe_o <= ~m_sleep;
            if (samp_rise) begin
                hold_a <= word_a;
                hold_b <= word_b;
                ilv_ph <= ~ilv_ph;
                fwd_clock_pos_o <= 1'b1;
                if (m_ilv) begin
                    chan_b_bus_o <= ilv_ph ? word_b : word_a;
                end else if (ddr_sel) begin
                    chan_a_bus_o <= {7'h00, word_a[12], word_a[10], word_a[8], word_a[6],
                                     word_a[4], word_a[2], word_a[0]};
                    chan_b_bus_o <= {7'h00, word_b[12], word_b[10], word_b[8], word_b[6],
                                     word_b[4], word_b[2], word_b[0]};
                end else begin
                    chan_a_bus_o <= word_a; // CMOS
                    chan_b_bus_o <= word_b;
                end
            end else if (samp_fall) begin
                fwd_clock_pos_o <= 1'b0;
                if (ddr_sel & ~m_ilv) begin
                    chan_a_bus_o <= {7'h00, hold_a[13], hold_a[11], hold_a[9], hold_a[7],
                                     hold_a[5], hold_a[3], hold_a[1]};
                    chan_b_bus_o <= {7'h00, hold_b[13], hold_b[11], hold_b[9], hold_b[7],
                                     hold_b[5], hold_b[3], hold_b[1]};
                end
            end
        end
    end

    // wishbone classic slave, ack one cycle after request
    // a held request acks every other cycle
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `ADPP_CTRL_RST;
            gain <= `ADPP_GAIN_RST;
            trim <= `ADPP_TRIM_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req & wb_we_i & wb_sel_i[0]) begin
                case (wb_adr_i)
                    `ADPP_REG_CTRL: ctrl <= wb_dat_i[7:0];
                    // gain and trim accepted only with processing enabled
                    `ADPP_REG_GAIN: if (digen) gain <= (wb_dat_i[3:0] > `ADPP_GAIN_MAX) ?
                                        `ADPP_GAIN_MAX : wb_dat_i[3:0];
                    `ADPP_REG_TRIM: if (digen) trim <= wb_dat_i[7:0];
                    default: ;
                endcase
            end
            if (req & ~wb_we_i) begin
                case (wb_adr_i)
                    `ADPP_REG_CTRL:   wb_dat_o <= {24'h00_0000, ctrl};
                    `ADPP_REG_GAIN:   wb_dat_o <= {28'h000_0000, gain};
                    `ADPP_REG_TRIM:   wb_dat_o <= {24'h00_0000, trim};
                    `ADPP_REG_STATUS: wb_dat_o <= {25'h000_0000, slow, valid_b, valid_a,
                                                   m_ilv, m_stby_b, m_stby_a, m_sleep};
                    default:          wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* File: adpp_top_properties.sv */
module adpp_props (
    input logic        clk_i,
    input logic        rst_i,
    input logic [3:0]  wb_adr_i,
    input logic        wb_we_i,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        samp_clk_i,
    input logic        chan_a_bus_oe_o,
    input logic        chan_b_bus_oe_o,
    input logic        fwd_clock_pos_o,
    input logic        fwd_clock_oe_o,
    input logic        core_sleep_o,
    input logic        low_power_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] quiet;  // cycles since the sample clock last moved
    logic       samp_q; // sample clock one cycle ago
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // saturating idle counter, so a stopped clock never wraps back
    always_ff @(posedge clk_i) begin
        samp_q <= samp_clk_i;
        if (rst_i || samp_clk_i != samp_q) begin
            quiet <= 6'h00;
        end else if (quiet != 6'h3F) begin
            quiet <= quiet + 6'h01;
        end
    end
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_asleep;
        core_sleep_o [*3];
    endsequence
    property p_ack_next;
        s_take |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_dat_hold;
        $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i;
    endproperty
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0000_0000;
    endproperty
    property p_sleep_float;
        s_asleep |-> !(chan_a_bus_oe_o || chan_b_bus_oe_o || fwd_clock_oe_o);
    endproperty
    property p_slow;
        quiet == 6'h32 |-> low_power_o;
    endproperty
    property p_fwd_follow;
        $rose(fwd_clock_pos_o) |-> quiet < 6'h08;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_dat_hold: assert property (p_dat_hold)
        else $error("read data moved outside a read");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_sleep_float: assert property (p_sleep_float)
        else $error("outputs driven while asleep");
    a_slow: assert property (p_slow)
        else $error("stopped sample clock not in low power");
    a_fwd_follow: assert property (p_fwd_follow)
        else $error("forwarded clock rose without a sample edge");
endmodule

/* File: adpp_rx.sv */
// receiver model: latches words with the forwarded clock
module adpp_rx (
    input  logic        clk_i,  // receiver clock
    input  logic        fwd_i,  // forwarded clock from the block
    input  logic        ddr_i,  // double data rate selected
    input  logic [13:0] bus_i,  // data pins
    output logic        cap_o,  // one-cycle pulse per word
    output logic [13:0] word_o  // last word taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       fwd_q; // forwarded clock one cycle ago
    logic [6:0] even;  // even bits of the rising half
    integer     k;
    // oversampled capture: pins have settled one cycle after each edge
    always @(posedge clk_i) begin
        fwd_q <= fwd_i;
        cap_o <= 1'b0;
        if (fwd_i && !fwd_q) begin
            even <= bus_i[6:0];
            if (!ddr_i) begin
                word_o <= bus_i;
                cap_o  <= 1'b1;
            end
        end
        // odd bits arrive on the falling half and complete the word
        if (!fwd_i && fwd_q && ddr_i) begin
            for (k = 0; k < 7; k++) begin
                word_o[2*k]   <= even[k];
                word_o[2*k+1] <= bus_i[k];
            end
            cap_o <= 1'b1;
        end
    end
endmodule

/* File: adpp_top_tb.sv */
`include "adpp_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module adpp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, samp_clk_i;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [13:0] raw_a_i, raw_b_i, chan_a_bus_o, chan_b_bus_o, word_a, word_b;
    logic        ovr_a_i, ovr_b_i, format_select_pin_i, serial_select_pin_i;
    logic        power_pin_1_i, power_pin_2_i, power_pin_3_i, chan_a_bus_oe_o;
    logic        chan_b_bus_oe_o, fwd_clock_pos_o, fwd_clock_oe_o, ddr_mode_o;
    logic        core_sleep_o, core_stby_a_o, core_stby_b_o, low_power_o;
    logic        cap_a, cap_b, samp_en, chk_en, tc, fq; // stream control
    logic [2:0]  ph;                                   // phase in a sample
    logic [7:0]  n, m, lat;                            // sample counts
    logic [14:0] hist_a [256];                         // {ovr, raw} per sample
    logic [14:0] hist_b [256];
    logic [15:0] lfsr;
    logic [2:0]  codes [5];                            // power pin codes
    int          num_errors, tests_run, i;
    // wake counts shortened so the run stays short
    adpp_top #(.WAKE_FULL_CYC(20), .WAKE_STBY_CYC(10)) adpp_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .samp_clk_i(samp_clk_i),
        .raw_a_i(raw_a_i), .raw_b_i(raw_b_i), .ovr_a_i(ovr_a_i), .ovr_b_i(ovr_b_i),
        .power_pin_1_i(power_pin_1_i), .power_pin_2_i(power_pin_2_i),
        .power_pin_3_i(power_pin_3_i), .format_select_pin_i(format_select_pin_i),
        .serial_select_pin_i(serial_select_pin_i), .chan_a_bus_o(chan_a_bus_o),
        .chan_a_bus_oe_o(chan_a_bus_oe_o), .chan_b_bus_o(chan_b_bus_o),
        .chan_b_bus_oe_o(chan_b_bus_oe_o), .fwd_clock_pos_o(fwd_clock_pos_o),
        .fwd_clock_oe_o(fwd_clock_oe_o), .ddr_mode_o(ddr_mode_o),
        .core_sleep_o(core_sleep_o), .core_stby_a_o(core_stby_a_o),
        .core_stby_b_o(core_stby_b_o), .low_power_o(low_power_o));
    adpp_rx rx_a_i (.clk_i(clk_i), .fwd_i(fwd_clock_pos_o), .ddr_i(ddr_mode_o),
        .bus_i(chan_a_bus_o), .cap_o(cap_a), .word_o(word_a));
    adpp_rx rx_b_i (.clk_i(clk_i), .fwd_i(fwd_clock_pos_o), .ddr_i(ddr_mode_o),
        .bus_i(chan_b_bus_o), .cap_o(cap_b), .word_o(word_b));
    always #12.5 clk_i = ~clk_i;
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // expected code for one sample: saturation first, then coding
    function automatic logic [13:0] enc(input logic [14:0] s, input logic t);
        if (s[14]) return t ? 14'h1FFF : 14'h3FFF;
        return t ? s[13:0] ^ 14'h2000 : s[13:0];
    endfunction
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one classic cycle: hold until ack is seen, release only then
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int w;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        w = 0;
        do begin
            @(posedge clk_i);
            w++;
        end while (wb_ack_o !== 1'b1 && w < 20);
        if (wb_ack_o !== 1'b1) begin
            num_errors++;
            complete_run();
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // one stream setting: let the pipe refill, then compare every word
    task automatic phase(input logic [31:0] c, input logic [7:0] l, input logic t);
        chk_en <= 1'b0;
        wb(1'b1, `ADPP_REG_CTRL, c, q);
        lat <= l;
        tc  <= t;
        repeat (200) @(posedge clk_i);
        chk_en <= 1'b1;
        repeat (320) @(posedge clk_i);
    endtask
    // 200 ns sample clock; raw data moves well away from its rising edge
    always @(posedge clk_i) begin
        fq <= fwd_clock_pos_o;
        if (fwd_clock_pos_o && !fq) m <= n;
        if (samp_en) begin
            ph <= ph + 3'h1;
            samp_clk_i <= (ph > 3'h2) && (ph < 3'h7);
            if (ph == 3'h3) begin
                hist_a[n] <= {ovr_a_i, raw_a_i};
                hist_b[n] <= {ovr_b_i, raw_b_i};
                n <= n + 8'h01;
            end
            if (ph == 3'h1) begin
                lfsr    <= step(lfsr);
                raw_a_i <= (lfsr[2:0] == 3'h0) ? 14'h0000 : lfsr[13:0];
                raw_b_i <= {lfsr[6:0], lfsr[15:9]};
                ovr_a_i <= lfsr[15:13] == 3'h7;
                ovr_b_i <= lfsr[5:3] == 3'h0;
            end
        end
        if (chk_en && cap_a) `CHK(word_a, enc(hist_a[m - 8'h01 - lat], tc))
        if (chk_en && cap_b) `CHK(word_b, enc(hist_b[m - 8'h01 - lat], tc))
    end
    initial begin
        {wb_we_i, wb_cyc_i, wb_stb_i, samp_clk_i, samp_en, chk_en, tc, fq} = '0;
        {ovr_a_i, ovr_b_i, format_select_pin_i, serial_select_pin_i} = '0;
        {power_pin_1_i, power_pin_2_i, power_pin_3_i, ph, n, m} = '0;
        {wb_adr_i, wb_dat_i, raw_a_i, raw_b_i} = '0;
        wb_sel_i = 4'h1;
        rst_i = 1'b1;
        lfsr = 16'h0018;
        lat = 8'h10;
        codes = '{3'h0, 3'h4, 3'h2, 3'h5, 3'h7};
        num_errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `ADPP_REG_CTRL, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
        wb(1'b0, `ADPP_REG_GAIN, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
        wb(1'b0, `ADPP_REG_TRIM, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0002)
        wb(1'b0, 4'h2, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
        wb(1'b1, `ADPP_REG_GAIN, 32'h0000_0005, q);
        wb(1'b0, `ADPP_REG_GAIN, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
        samp_en <= 1'b1;
        phase(32'h0000_0000, 8'h10, 1'b0);
        phase(32'h0000_0010, 8'h10, 1'b1);
        phase(32'h0000_0030, 8'h10, 1'b1);
        `CHK(ddr_mode_o, 1'b1)
        chk_en <= 1'b0;
        wb(1'b1, `ADPP_REG_CTRL, 32'h0000_0001, q);
        wb(1'b1, `ADPP_REG_GAIN, 32'h0000_000F, q);
        wb(1'b0, `ADPP_REG_GAIN, 32'h0000_0000, q);
        `CHK(q, 32'h0000_000C)
        wb(1'b1, `ADPP_REG_GAIN, 32'h0000_0000, q);
        wb(1'b1, `ADPP_REG_TRIM, 32'h0000_00F2, q);
        wb(1'b0, `ADPP_REG_TRIM, 32'h0000_0000, q);
        `CHK(q, 32'h0000_00F2)
        phase(32'h0000_0001, 8'h14, 1'b0);
        chk_en <= 1'b0;
        wb(1'b1, `ADPP_REG_CTRL, 32'h0000_0080, q);
        for (i = 0; i < 5; i++) begin
            {power_pin_1_i, power_pin_2_i, power_pin_3_i} <= codes[i];
            repeat (60) @(posedge clk_i);
            `CHK(core_sleep_o, codes[i] == 3'h4)
            `CHK(core_stby_a_o, codes[i] == 3'h5)
            `CHK(chan_b_bus_oe_o, codes[i] != 3'h4)
            if (codes[i] == 3'h7) `CHK(chan_a_bus_oe_o, 1'b0)
        end
        samp_en <= 1'b0;
        repeat (60) @(posedge clk_i);
        `CHK(low_power_o, 1'b1)
        complete_run();
    end
endmodule
bind adpp_top adpp_props adpp_props_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .samp_clk_i(samp_clk_i),
    .chan_a_bus_oe_o(chan_a_bus_oe_o), .chan_b_bus_oe_o(chan_b_bus_oe_o),
    .fwd_clock_pos_o(fwd_clock_pos_o), .fwd_clock_oe_o(fwd_clock_oe_o),
    .core_sleep_o(core_sleep_o), .low_power_o(low_power_o));
